// >>> rtl/tcb_ctrl_b.sv
// control-B shared set/clear register with timer-domain command execution
`timescale 1ns/10ps
// Function
// - clear and set views read back one shared control-B state.
// - writes take effect in the timer domain only after transfer; ramp commands act at the next update without one.
// - command codes: none, restart, stop, forced update, count read-back.
// - a pending command runs on the next prescaled timer tick.
// - command field reads zero once the command has run.
// - writing zero to the command field changes nothing.
// - set-view write of a valid nonzero command makes it pending.
// - clear-view ones in command or ramp field cancel that pending command.
// - ramp codes: alternate, force B, force A, hold current cycle.
// - on update the ramp command runs, cycle flag updates, field clears.
// - set-view nonzero ramp command registers; zero writes do nothing.
// - single-run halts at overflow/underflow or stop, else keeps wrapping.
// - set-view one on single-run bit enables it.
// - clear-view one disables single-run; zero writes leave it.
// - unlocked update copies buffered values to active ones; locked, none.
// - lock is ignored while input capture is enabled.
// - clear-view one on lock bit unlocks; zero does nothing.
// - counter counts up with direction 0, down with 1.
// - clear-view one on direction bit makes counter count up.
// - set-view one on lock bit locks buffered updates.
// - auto-lock sets the lock on overflow, underflow or retrigger.
// - busy flag set on control-B write, cleared when transfer completes.
module tcb_ctrl_b (
  input wire logic i_sys_clk, // system clock, 50 MHz
  input wire logic i_rst, // asynchronous reset, active high
  input wire logic [7:0] i_addr, // register byte offset
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr_en, // write strobe
  input wire logic i_rd_en, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after read strobe
  input wire logic [2:0] i_presc_sel, // prescaler factor select
  input wire logic i_dual_slope, // dual-ramp mode active
  input wire logic i_auto_lock, // auto lock enable
  input wire logic i_capture_en, // input capture enabled
  input wire logic i_update_evt, // hardware update condition pulse
  input wire logic i_wrap_evt, // overflow or underflow pulse
  input wire logic i_retrig_evt, // external retrigger pulse
  output tcb_pkg::tcb_cmd_t o_cmd, // executed command pulses
  output logic o_sync_busy, // control-B transfer pending
  output logic o_count_down, // counter direction, 1 = down
  output logic o_single_run, // single-run active in timer domain
  output logic o_halt, // stop counting pulse
  output logic o_buffer_copy, // copy buffers to active pulse
  output logic o_ramp_cycle_flag // current ramp cycle, 1 = cycle B
);
  import tcb_pkg::*;

  tcb_state_t st;
  tcb_state_t next_st;
  logic [TCB_PRESC_W-1:0] div_last;
  logic tick;
  logic wr_clr;
  logic wr_set;
  logic apply;
  logic [7:0] ctrl_byte;

  always_comb
  begin
    case (i_presc_sel)
      3'h0: div_last = 10'h000;
      3'h1: div_last = 10'h001;
      3'h2: div_last = 10'h003;
      3'h3: div_last = 10'h007;
      3'h4: div_last = 10'h00f;
      3'h5: div_last = 10'h03f;
      3'h6: div_last = 10'h0ff;
      default: div_last = 10'h3ff;
    endcase
  end

  assign tick = (st.presc >= div_last);
  assign wr_clr = i_wr_en && (i_addr == TCB_OFS_CLEAR);
  assign wr_set = i_wr_en && (i_addr == TCB_OFS_SET);
  // a write landing on the tick waits for the next one, its data is not stored yet
  assign apply = tick && st.busy && !wr_clr && !wr_set;
  assign ctrl_byte = st.ctrl;

  always_comb
  begin
    next_st = st;
    next_st.cmd_pulse = '0;
    next_st.halt = 1'b0;
    next_st.copy = 1'b0;
    next_st.rdata = 8'h00;
    next_st.presc = tick ? '0 : st.presc + 10'h001;
    // cycles a transfer has waited, watched by the busy bound check
    next_st.busy_age = (!st.busy || wr_clr || wr_set) ? '0 : st.busy_age + 11'h001;

    // timer-domain side: run the stored command, take over settings
    if (apply)
    begin
      next_st.busy = 1'b0;
      next_st.eff_single = st.ctrl.single_run;
      next_st.eff_lock = st.ctrl.lock;
      next_st.eff_dir = st.ctrl.dir;
      case (st.ctrl.cmd)
        TCB_CMD_RETRIG: next_st.cmd_pulse.retrigger = 1'b1;
        TCB_CMD_STOP: next_st.cmd_pulse.stop = 1'b1;
        TCB_CMD_UPDATE: next_st.cmd_pulse.update = 1'b1;
        TCB_CMD_READBACK: next_st.cmd_pulse.readback = 1'b1;
        default: next_st.cmd_pulse = '0;
      endcase
      next_st.ctrl.cmd = TCB_CMD_NONE;
    end

    // single-run halt on wrap, stop command halts in any case
    if ((st.eff_single && i_wrap_evt) || (apply && st.ctrl.cmd == TCB_CMD_STOP))
      next_st.halt = 1'b1;

    // forced update copies regardless of the lock
    if ((i_update_evt && (!st.eff_lock || i_capture_en)) ||
        (apply && st.ctrl.cmd == TCB_CMD_UPDATE))
      next_st.copy = 1'b1;

    if (i_update_evt && i_dual_slope)
    begin
      case (st.ctrl.ramp_cmd)
        TCB_RAMP_ALT: next_st.ramp_flag = !st.ramp_flag;
        TCB_RAMP_FORCE_B: next_st.ramp_flag = 1'b1;
        TCB_RAMP_FORCE_A: next_st.ramp_flag = 1'b0;
        TCB_RAMP_HOLD: next_st.ramp_flag = st.ramp_flag;
        default: next_st.ramp_flag = st.ramp_flag;
      endcase
      next_st.ctrl.ramp_cmd = TCB_RAMP_ALT;
    end

    // bus side comes after the timer side so that a write wins over a same-cycle clear
    if (wr_clr)
    begin
      if (i_wdata[TCB_CMD_HI:TCB_CMD_LO] != 3'h0)
        next_st.ctrl.cmd = TCB_CMD_NONE;
      if (i_wdata[TCB_RAMP_HI:TCB_RAMP_LO] != 2'h0)
        next_st.ctrl.ramp_cmd = TCB_RAMP_ALT;
      if (i_wdata[TCB_BIT_SINGLE])
        next_st.ctrl.single_run = 1'b0;
      if (i_wdata[TCB_BIT_LOCK])
        next_st.ctrl.lock = 1'b0;
      if (i_wdata[TCB_BIT_DIR])
        next_st.ctrl.dir = 1'b0;
      next_st.busy = 1'b1;
    end
    if (wr_set)
    begin
      // codes above the read-back command are not valid and are dropped
      if (i_wdata[TCB_CMD_HI:TCB_CMD_LO] != 3'h0 &&
          i_wdata[TCB_CMD_HI:TCB_CMD_LO] <= TCB_CMD_READBACK)
        next_st.ctrl.cmd = i_wdata[TCB_CMD_HI:TCB_CMD_LO];
      if (i_wdata[TCB_RAMP_HI:TCB_RAMP_LO] != 2'h0)
        next_st.ctrl.ramp_cmd = i_wdata[TCB_RAMP_HI:TCB_RAMP_LO];
      if (i_wdata[TCB_BIT_SINGLE])
        next_st.ctrl.single_run = 1'b1;
      if (i_wdata[TCB_BIT_LOCK])
        next_st.ctrl.lock = 1'b1;
      if (i_wdata[TCB_BIT_DIR])
        next_st.ctrl.dir = 1'b1;
      next_st.busy = 1'b1;
    end
    // hardware lock set wins over a same-cycle clear-view unlock
    if (i_auto_lock && (i_wrap_evt || i_retrig_evt))
    begin
      next_st.ctrl.lock = 1'b1;
      next_st.eff_lock = 1'b1;
    end

    if (i_rd_en)
    begin
      if (i_addr == TCB_OFS_CLEAR || i_addr == TCB_OFS_SET)
        next_st.rdata = ctrl_byte;
      else if (i_addr == TCB_OFS_STATUS)
      begin
        next_st.rdata[TCB_STS_BUSY] = st.busy;
        next_st.rdata[TCB_STS_RAMP] = st.ramp_flag;
      end
      else
        next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.ctrl <= TCB_CTRL_RESET;
    end
    else
      st <= next_st;
  end

  assign o_rdata = st.rdata;
  assign o_cmd = st.cmd_pulse;
  assign o_sync_busy = st.busy;
  assign o_count_down = st.eff_dir;
  assign o_single_run = st.eff_single;
  assign o_halt = st.halt;
  assign o_buffer_copy = st.copy;
  assign o_ramp_cycle_flag = st.ramp_flag;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  property p_views_agree;
    i_rd_en && (i_addr == TCB_OFS_CLEAR || i_addr == TCB_OFS_SET)
      |=> o_rdata == $past(ctrl_byte);
  endproperty
  a_views_agree: assert property (p_views_agree)
    else $error("control-B read does not show the shared state");

  property p_cmd_on_tick;
    (o_cmd != '0) |-> $past(tick) && $past(st.busy);
  endproperty
  a_cmd_on_tick: assert property (p_cmd_on_tick)
    else $error("command pulse without a prescaled tick");

  property p_cmd_reads_zero;
    apply && !i_wr_en ##1 !i_wr_en |=> st.ctrl.cmd == TCB_CMD_NONE;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command field not zero after execution");

  property p_zero_cmd_write;
    i_wr_en && i_wdata[TCB_CMD_HI:TCB_CMD_LO] == 3'h0 && !apply
      |=> st.ctrl.cmd == $past(st.ctrl.cmd);
  endproperty
  a_zero_cmd_write: assert property (p_zero_cmd_write)
    else $error("zero command write changed the pending command");

  property p_clear_cancels;
    wr_clr && i_wdata[TCB_CMD_HI:TCB_CMD_LO] != 3'h0 |=> st.ctrl.cmd == TCB_CMD_NONE;
  endproperty
  a_clear_cancels: assert property (p_clear_cancels)
    else $error("clear view did not cancel the pending command");

  property p_stop_halts;
    o_cmd.stop |-> o_halt;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("stop command did not halt the counter");

  property p_single_halt;
    st.eff_single && i_wrap_evt |=> o_halt;
  endproperty
  a_single_halt: assert property (p_single_halt)
    else $error("single run did not halt at wrap");

  property p_lock_blocks;
    i_update_evt && st.eff_lock && !i_capture_en && !apply |=> !o_buffer_copy;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("buffer copy while locked");

  property p_capture_overrides;
    i_update_evt && i_capture_en |=> o_buffer_copy;
  endproperty
  a_capture_overrides: assert property (p_capture_overrides)
    else $error("lock blocked copy during capture");

  property p_auto_lock;
    i_auto_lock && i_retrig_evt && !wr_clr |=> st.ctrl.lock && st.eff_lock;
  endproperty
  a_auto_lock: assert property (p_auto_lock)
    else $error("auto lock did not set the lock");

  property p_busy_cycle;
    (wr_clr || wr_set) |=> o_sync_busy;
  endproperty
  a_busy_cycle: assert property (p_busy_cycle)
    else $error("busy flag not set by a control-B write");

  // the transfer must finish within one slowest prescaler period
  property p_busy_bounded;
    o_sync_busy |-> st.busy_age < TCB_BUSY_MAX;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded)
    else $error("control-B transfer took too long");

  property p_dir_clear;
    wr_clr && i_wdata[TCB_BIT_DIR] |=> !st.ctrl.dir;
  endproperty
  a_dir_clear: assert property (p_dir_clear)
    else $error("clear view did not clear direction");

  property p_set_cmd;
    wr_set && i_wdata[TCB_CMD_HI:TCB_CMD_LO] != TCB_CMD_NONE &&
      i_wdata[TCB_CMD_HI:TCB_CMD_LO] <= TCB_CMD_READBACK
      |=> st.ctrl.cmd == $past(i_wdata[TCB_CMD_HI:TCB_CMD_LO]);
  endproperty
  a_set_cmd: assert property (p_set_cmd)
    else $error("set view did not register the command");

  property p_bad_cmd;
    wr_set && i_wdata[TCB_CMD_HI:TCB_CMD_LO] > TCB_CMD_READBACK |=> st.ctrl.cmd == $past(st.ctrl.cmd);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("invalid command code was registered");

  property p_readback_decode;
    apply && st.ctrl.cmd == TCB_CMD_READBACK |=> o_cmd == 4'h1;
  endproperty
  a_readback_decode: assert property (p_readback_decode)
    else $error("read-back command decoded wrongly");

  property p_transfer;
    apply |=> o_count_down == $past(st.ctrl.dir) && o_single_run == $past(st.ctrl.single_run);
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("settings not taken over at the transfer");

  property p_settings_hold;
    !apply |=> $stable(o_count_down) && $stable(o_single_run);
  endproperty
  a_settings_hold: assert property (p_settings_hold)
    else $error("timer-side settings changed without a transfer");

  property p_ramp_force;
    i_update_evt && i_dual_slope && (st.ctrl.ramp_cmd[1] != st.ctrl.ramp_cmd[0])
      |=> o_ramp_cycle_flag == $past(st.ctrl.ramp_cmd[0]);
  endproperty
  a_ramp_force: assert property (p_ramp_force)
    else $error("forced ramp cycle not taken");

  property p_ramp_idle;
    !(i_update_evt && i_dual_slope) |=> $stable(o_ramp_cycle_flag);
  endproperty
  a_ramp_idle: assert property (p_ramp_idle)
    else $error("ramp cycle flag moved without an update");

  property p_ramp_clears;
    i_update_evt && i_dual_slope && !wr_set |=> st.ctrl.ramp_cmd == TCB_RAMP_ALT;
  endproperty
  a_ramp_clears: assert property (p_ramp_clears)
    else $error("ramp command not cleared after the update");

  property p_ramp_set;
    wr_set && i_wdata[TCB_RAMP_HI:TCB_RAMP_LO] != 2'h0
      |=> st.ctrl.ramp_cmd == $past(i_wdata[TCB_RAMP_HI:TCB_RAMP_LO]);
  endproperty
  a_ramp_set: assert property (p_ramp_set)
    else $error("set view did not register the ramp command");

  property p_single_set;
    wr_set && i_wdata[TCB_BIT_SINGLE] |=> st.ctrl.single_run;
  endproperty
  a_single_set: assert property (p_single_set)
    else $error("set view did not enable single run");

  property p_single_clear;
    wr_clr && i_wdata[TCB_BIT_SINGLE] |=> !st.ctrl.single_run;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("clear view did not disable single run");

  property p_lock_clear;
    wr_clr && i_wdata[TCB_BIT_LOCK] && !(i_auto_lock && (i_wrap_evt || i_retrig_evt))
      |=> !st.ctrl.lock;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("clear view did not unlock");

  property p_lock_set;
    wr_set && i_wdata[TCB_BIT_LOCK] |=> st.ctrl.lock;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("set view did not lock");

  property p_dir_set;
    wr_set && i_wdata[TCB_BIT_DIR] |=> st.ctrl.dir;
  endproperty
  a_dir_set: assert property (p_dir_set)
    else $error("set view did not set direction");

  c_stop_run: cover property (wr_set ##[1:1000] o_cmd.stop);
  c_readback: cover property (o_cmd.readback);
  c_capture_copy: cover property (i_update_evt && i_capture_en && st.eff_lock);
  c_ramp_force: cover property (i_dual_slope && i_update_evt && st.ctrl.ramp_cmd != 2'h0);
  c_auto_lock: cover property (i_auto_lock && i_wrap_evt && !st.ctrl.lock);
endmodule

// >>> rtl/tcb_pkg.sv
// shared constants and types of the control-B set/clear block
package tcb_pkg;
  localparam logic [7:0] TCB_OFS_CLEAR = 8'h04;
  localparam logic [7:0] TCB_OFS_SET = 8'h05;
  localparam logic [7:0] TCB_OFS_STATUS = 8'h0a;
  localparam logic [7:0] TCB_CTRL_RESET = 8'h00;
  localparam int TCB_CMD_HI = 7;
  localparam int TCB_CMD_LO = 5;
  localparam int TCB_RAMP_HI = 4;
  localparam int TCB_RAMP_LO = 3;
  localparam int TCB_BIT_SINGLE = 2;
  localparam int TCB_BIT_LOCK = 1;
  localparam int TCB_BIT_DIR = 0;
  localparam int TCB_STS_BUSY = 0;
  localparam int TCB_STS_RAMP = 1;
  localparam logic [2:0] TCB_CMD_NONE = 3'h0;
  localparam logic [2:0] TCB_CMD_RETRIG = 3'h1;
  localparam logic [2:0] TCB_CMD_STOP = 3'h2;
  localparam logic [2:0] TCB_CMD_UPDATE = 3'h3;
  localparam logic [2:0] TCB_CMD_READBACK = 3'h4;
  localparam logic [1:0] TCB_RAMP_ALT = 2'h0;
  localparam logic [1:0] TCB_RAMP_FORCE_B = 2'h1;
  localparam logic [1:0] TCB_RAMP_FORCE_A = 2'h2;
  localparam logic [1:0] TCB_RAMP_HOLD = 2'h3;
  localparam int TCB_PRESC_W = 10;
  localparam int TCB_BUSY_MAX = 1024;

  typedef struct packed {
    logic retrigger;
    logic stop;
    logic update;
    logic readback;
  } tcb_cmd_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic [1:0] ramp_cmd;
    logic single_run;
    logic lock;
    logic dir;
  } tcb_ctrl_t;

  typedef struct packed {
    tcb_ctrl_t ctrl;
    logic eff_single;
    logic eff_lock;
    logic eff_dir;
    logic busy;
    logic ramp_flag;
    logic [TCB_PRESC_W-1:0] presc;
    logic [7:0] rdata;
    tcb_cmd_t cmd_pulse;
    logic halt;
    logic copy;
    logic [10:0] busy_age;
  } tcb_state_t;
endpackage

// >>> bench/test_tcb_ctrl_b.sv
// self-checking bench of the control-B set/clear block
`timescale 1ns/10ps
module test_tcb_ctrl_b;
  import tcb_pkg::*;
  logic i_sys_clk = 0, i_rst = 1, i_wr_en = 0, i_rd_en = 0;
  logic [7:0] i_addr = '0, i_wdata = '0, o_rdata, d, m;
  logic [2:0] i_presc_sel = '0;
  logic i_dual_slope = 0, i_auto_lock = 0, i_capture_en = 0;
  logic i_update_evt = 0, i_wrap_evt = 0, i_retrig_evt = 0;
  tcb_cmd_t o_cmd;
  logic o_sync_busy, o_count_down, o_single_run, o_halt, o_buffer_copy, o_ramp_cycle_flag;
  logic [5:0] seen = '0;
  int errors = 0, total_checks = 0, cycles = 0;

  tcb_ctrl_b u_tcb_ctrl_b (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
    .i_presc_sel(i_presc_sel), .i_dual_slope(i_dual_slope), .i_auto_lock(i_auto_lock),
    .i_capture_en(i_capture_en), .i_update_evt(i_update_evt), .i_wrap_evt(i_wrap_evt),
    .i_retrig_evt(i_retrig_evt), .o_cmd(o_cmd), .o_sync_busy(o_sync_busy),
    .o_count_down(o_count_down), .o_single_run(o_single_run), .o_halt(o_halt),
    .o_buffer_copy(o_buffer_copy), .o_ramp_cycle_flag(o_ramp_cycle_flag));

  initial forever #10 i_sys_clk = ~i_sys_clk;
  // pulses are sticky here so a check may come a cycle later
  always @(posedge i_sys_clk) seen <= seen | {o_cmd, o_halt, o_buffer_copy};

  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1 d = o_rdata;
  endtask

  // wait until the transfer ends, at most 2100 cycles, then check busy is low
  task automatic settle();
    int n;
    n = 0;
    #1;
    while (o_sync_busy !== 1'b0 && n < 2100)
    begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    chk("busy", {7'h0, o_sync_busy}, 8'h00);
  endtask

  task automatic ev(input int k);
    #1 seen = '0;
    @(posedge i_sys_clk);
    i_update_evt <= (k == 0);
    i_wrap_evt <= (k == 1);
    i_retrig_evt <= (k == 2);
    @(posedge i_sys_clk);
    {i_update_evt, i_wrap_evt, i_retrig_evt} <= 3'h0;
    @(posedge i_sys_clk);
    #1;
  endtask

  function automatic logic [7:0] exp_seen(input int c);
    logic [7:0] e;
    e = 8'h00;
    if (c >= 1 && c <= 4)
      e[6 - c] = 1'b1;
    e[1] = (c == 2);
    e[0] = (c == 3);
    return e;
  endfunction

  initial
  begin
    int v;
    logic [1:0] r;
    logic f;
    v = $urandom(32'hfc3e51c8);
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(TCB_OFS_CLEAR);
    chk("clear reset", d, TCB_CTRL_RESET);
    rd(TCB_OFS_SET);
    chk("set reset", d, TCB_CTRL_RESET);
    rd(8'h33);
    chk("unmapped", d, 8'h00);
    m = TCB_CTRL_RESET;
    for (int i = 0; i < 16; i++)
    begin
      v = $urandom;
      i_presc_sel <= v[5:3];
      m = v[6] ? (m | {5'h0, v[2:0]}) : (m & ~{5'h0, v[2:0]});
      wr(v[6] ? TCB_OFS_SET : TCB_OFS_CLEAR, {5'h0, v[2:0]});
      rd(TCB_OFS_CLEAR);
      chk("clear view", d, m);
      rd(TCB_OFS_SET);
      chk("set view", d, m);
      settle();
      chk("dir", {7'h0, o_count_down}, {7'h0, m[0]});
      chk("single", {7'h0, o_single_run}, {7'h0, m[2]});
    end
    wr(8'h06, 8'hff);
    rd(TCB_OFS_CLEAR);
    chk("stray write", d, m);
    // slowest tick leaves a long window to cancel in
    i_presc_sel <= 3'h7;
    wr(TCB_OFS_CLEAR, 8'hff);
    settle();
    seen = '0;
    wr(TCB_OFS_SET, {TCB_CMD_STOP, 5'h00});
    rd(TCB_OFS_STATUS);
    chk("busy set", d & 8'h01, 8'h01);
    wr(TCB_OFS_SET, 8'h01);
    rd(TCB_OFS_CLEAR);
    chk("cmd kept", d, {TCB_CMD_STOP, 5'h01});
    chk("early", {2'h0, seen}, 8'h00);
    wr(TCB_OFS_CLEAR, 8'he1);
    rd(TCB_OFS_SET);
    chk("cancel", d, 8'h00);
    settle();
    @(posedge i_sys_clk);
    #1 chk("no stop", {2'h0, seen}, 8'h00);
    for (int c = 1; c < 8; c++)
    begin
      i_presc_sel <= 3'($urandom_range(4));
      #1 seen = '0;
      wr(TCB_OFS_SET, {3'(c), 5'h00});
      settle();
      @(posedge i_sys_clk);
      #1 chk("cmd pulse", {2'h0, seen}, exp_seen(c));
      rd(TCB_OFS_CLEAR);
      chk("cmd read", d, 8'h00);
    end
    i_presc_sel <= 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      wr(k[1] ? TCB_OFS_SET : TCB_OFS_CLEAR, 8'h02);
      settle();
      i_capture_en <= k[0];
      ev(0);
      chk("copy", {7'h0, seen[0]}, {7'h0, !k[1] || k[0]});
    end
    i_capture_en <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      wr(k ? TCB_OFS_SET : TCB_OFS_CLEAR, 8'h04);
      settle();
      ev(1);
      chk("halt", {7'h0, seen[1]}, 8'(k));
    end
    i_auto_lock <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      wr(TCB_OFS_CLEAR, 8'h02);
      settle();
      ev(k);
      rd(TCB_OFS_SET);
      chk("auto lock", d & 8'h02, 8'h02);
    end
    i_auto_lock <= 1'b0;
    i_dual_slope <= 1'b1;
    f = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      r = (k == 0) ? TCB_RAMP_FORCE_A : 2'($urandom);
      if (r != TCB_RAMP_HOLD)
        f = (r == TCB_RAMP_ALT) ? !f : (r == TCB_RAMP_FORCE_B);
      wr(TCB_OFS_SET, {3'h0, r, 3'h0});
      settle();
      ev(0);
      chk("ramp flag", {7'h0, o_ramp_cycle_flag}, {7'h0, f});
      rd(TCB_OFS_CLEAR);
      chk("ramp field", d & 8'h18, 8'h00);
      rd(TCB_OFS_STATUS);
      chk("status ramp", d & 8'h02, {6'h0, f, 1'b0});
    end
    close_out();
  end
endmodule
